// [shared/ext_bus_defines.vh]
// Timing, phase and pin-position constants for the external memory bus port
`ifndef EXT_BUS_DEFINES_VH
`define EXT_BUS_DEFINES_VH

// ------------------------------------------------------------
// Machine cycle timing (one clock = one oscillator period)
// ------------------------------------------------------------
`define PH_LAST        4'hB
`define PH_SLOT_B      4'h6
`define PH_SLOT_A_END  4'h5
`define ALE_END        4'h2
`define ADDR_END       4'h3
`define SAMPLE_PH      4'h5
`define RD_START       4'h6
`define WR_START       4'h7
`define STB_END        4'hA
`define PH_ZERO        4'h0
`define RST_HOLD       5'h18

// ------------------------------------------------------------
// Shared function port bit positions
// ------------------------------------------------------------
`define SFP_SER_IN     0
`define SFP_SER_OUT    1
`define SFP_IRQ0       2
`define SFP_IRQ1       3
`define SFP_CNT0       4
`define SFP_CNT1       5
`define SFP_WR         6
`define SFP_RD         7
`define SFP_OE_MASK    8'hC2
`define PORT_IDLE      8'hFF
`define SYNC_RST_BIT   8
`define SYNC_SEL_BIT   9

`endif

// [logic/ext_bus_port.v]
// External program and data memory bus port
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defines.vh"

module ext_bus_port #(
   parameter WIDTH = 9,
   parameter DEPTH = 2
) (
   input  wire        i_clock,
   input  wire        i_resetn,
   input  wire        i_clock_enable,
   input  wire        i_reset_pin,
   input  wire        i_external_access_select,
   input  wire        i_code_protect_bit_one,
   input  wire        i_fetch_valid,
   input  wire [15:0] i_fetch_addr,
   output wire        o_fetch_ready,
   input  wire        i_move_valid,
   input  wire        i_move_write,
   input  wire        i_move_use_pointer,
   input  wire [15:0] i_move_addr,
   input  wire [7:0]  i_move_wdata,
   input  wire [7:0]  i_high_port_latch,
   output wire        o_move_ready,
   output wire        o_rd_valid,
   output wire [7:0]  o_rd_data,
   output wire        o_rd_is_code,
   input  wire        i_rd_ready,
   input  wire [7:0]  i_low_addr_data_port_in,
   output reg  [7:0]  o_low_addr_data_port_out,
   output wire [7:0]  o_low_addr_data_port_oe,
   output wire        o_low_addr_data_port_pullup,
   output reg  [7:0]  o_high_addr_port,
   output wire        o_address_latch_strobe,
   output wire        o_program_read_strobe_n,
   input  wire [7:0]  i_shared_function_port_in,
   output wire [7:0]  o_shared_function_port_out,
   output wire [7:0]  o_shared_function_port_oe,
   input  wire        i_serial_out,
   output wire        o_serial_in,
   output wire [1:0]  o_ext_irq,
   output wire [1:0]  o_counter_input,
   output wire        o_code_from_external,
   output wire        o_reset_active
);

   localparam CW = $clog2(DEPTH + 1);
   localparam PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ------------------------------------------------------------
   // Slot phase decode
   // ------------------------------------------------------------
   function [3:0] slot_phase;
      input [3:0] ph;
      begin
         slot_phase = (ph >= `PH_SLOT_B) ? (ph - `PH_SLOT_B) : ph;
      end
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   reg  [9:0] sync1_q;
   reg  [9:0] sync2_q;
   wire       rst_pin_s = sync2_q[`SYNC_RST_BIT];
   wire       sel_s     = sync2_q[`SYNC_SEL_BIT];

   // No reset: strap must stay visible while reset is active
   always @(posedge i_clock) begin
      if (i_clock_enable) begin
         sync1_q <= {i_external_access_select, i_reset_pin, i_shared_function_port_in};
         sync2_q <= sync1_q;
      end
   end

   assign o_serial_in     = sync2_q[`SFP_SER_IN];
   assign o_ext_irq       = {sync2_q[`SFP_IRQ1], sync2_q[`SFP_IRQ0]};
   assign o_counter_input = {sync2_q[`SFP_CNT1], sync2_q[`SFP_CNT0]};

   // ------------------------------------------------------------
   // Reset pin qualification and access select strap
   // ------------------------------------------------------------
   reg  [4:0] rst_cnt_q;
   reg        pin_rst_q;
   reg        sel_latched_q;
   wire       rst = !i_resetn || pin_rst_q;

   always @(posedge i_clock) begin
      if (!i_resetn) begin
         rst_cnt_q <= 5'h00;
         pin_rst_q <= 1'b0;
      end else if (i_clock_enable) begin
         if (!rst_pin_s) begin
            rst_cnt_q <= 5'h00;
            pin_rst_q <= 1'b0;
         end else if (rst_cnt_q < `RST_HOLD - 5'h01) begin
            rst_cnt_q <= rst_cnt_q + 5'h01;
         end else begin
            pin_rst_q <= 1'b1;
         end
      end
   end

   always @(posedge i_clock) begin
      if (i_clock_enable && rst) begin
         sel_latched_q <= sel_s;
      end
   end

   wire sel_eff  = i_code_protect_bit_one ? sel_latched_q : sel_s;
   wire code_ext = !sel_eff;
   assign o_code_from_external = code_ext;
   assign o_reset_active       = rst;

   // ------------------------------------------------------------
   // Read data buffer
   // ------------------------------------------------------------
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [PW-1:0]    wr_ptr_q;
   reg  [PW-1:0]    rd_ptr_q;
   reg  [CW-1:0]    count_q;
   wire             push;
   wire [WIDTH-1:0] push_data;
   wire             pop = o_rd_valid && i_rd_ready && i_clock_enable;
   wire             room = (count_q + {{(CW-1){1'b0}}, push}) < DEPTH;

   assign o_rd_valid   = (count_q != {CW{1'b0}});
   assign o_rd_data    = mem[rd_ptr_q][7:0];
   assign o_rd_is_code = mem[rd_ptr_q][8];

   always @(posedge i_clock) begin
      if (rst) begin
         wr_ptr_q <= {PW{1'b0}};
         rd_ptr_q <= {PW{1'b0}};
         count_q  <= {CW{1'b0}};
      end else if (i_clock_enable) begin
         if (push) begin
            mem[wr_ptr_q] <= push_data;
            wr_ptr_q <= (wr_ptr_q == DEPTH - 1) ? {PW{1'b0}} : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == DEPTH - 1) ? {PW{1'b0}} : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop};
      end
   end

   // ------------------------------------------------------------
   // Machine cycle sequencer
   // ------------------------------------------------------------
   reg  [3:0]  phase_q;
   reg         data_cyc_q;
   reg         write_q;
   reg         fetch_q;
   reg  [15:0] addr_q;
   reg  [7:0]  wdata_q;
   wire [3:0]  sph     = slot_phase(phase_q);
   wire        slot_end = (phase_q == `PH_LAST) || (phase_q == `PH_SLOT_A_END);
   wire        cyc_end  = (phase_q == `PH_LAST);
   wire        slot_b   = (phase_q >= `PH_SLOT_B);

   assign o_move_ready  = i_clock_enable && !rst && cyc_end
                          && (i_move_write || room);
   wire   take_move     = o_move_ready && i_move_valid;
   assign o_fetch_ready = i_clock_enable && !rst && slot_end && code_ext && room
                          && !take_move && !(data_cyc_q && !slot_b);
   wire   take_fetch    = o_fetch_ready && i_fetch_valid;

   assign push = i_clock_enable && !rst
                 && ((fetch_q && sph == `SAMPLE_PH)
                     || (data_cyc_q && !write_q && phase_q == `STB_END));
   assign push_data = {fetch_q, i_low_addr_data_port_in};

   always @(posedge i_clock) begin
      if (rst) begin
         phase_q          <= `PH_ZERO;
         data_cyc_q       <= 1'b0;
         write_q          <= 1'b0;
         fetch_q          <= 1'b0;
         addr_q           <= 16'h0000;
         wdata_q          <= 8'h00;
         o_high_addr_port <= `PORT_IDLE;
      end else if (i_clock_enable) begin
         phase_q <= cyc_end ? `PH_ZERO : phase_q + 4'h1;
         if (slot_end) begin
            fetch_q <= take_fetch;
            if (cyc_end) begin
               data_cyc_q <= take_move;
               write_q    <= take_move && i_move_write;
            end
            if (take_move) begin
               addr_q  <= i_move_addr;
               wdata_q <= i_move_wdata;
               o_high_addr_port <= i_move_use_pointer ? i_move_addr[15:8]
                                                      : i_high_port_latch;
            end else if (take_fetch) begin
               addr_q <= i_fetch_addr;
               o_high_addr_port <= i_fetch_addr[15:8];
            end else if (!(data_cyc_q && !slot_b)) begin
               o_high_addr_port <= i_high_port_latch;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Bus pin output registers and strobes
   // ------------------------------------------------------------
   wire addr_phase = (fetch_q || (data_cyc_q && !slot_b)) && (sph < `ADDR_END);
   wire wdata_phase = data_cyc_q && write_q && slot_b;
   wire rd_stb = data_cyc_q && !write_q && (phase_q >= `RD_START)
                 && (phase_q <= `STB_END);
   wire wr_stb = data_cyc_q && write_q && (phase_q >= `WR_START)
                 && (phase_q <= `STB_END);

   always @(posedge i_clock) begin
      if (rst) begin
         o_low_addr_data_port_out <= `PORT_IDLE;
      end else if (i_clock_enable) begin
         if (slot_end && take_move) begin
            o_low_addr_data_port_out <= i_move_addr[7:0];
         end else if (slot_end && take_fetch) begin
            o_low_addr_data_port_out <= i_fetch_addr[7:0];
         end else if (data_cyc_q && write_q && phase_q == `PH_SLOT_A_END) begin
            o_low_addr_data_port_out <= wdata_q;
         end
      end
   end

   assign o_low_addr_data_port_oe    = {8{!rst && (addr_phase || wdata_phase)}};
   assign o_low_addr_data_port_pullup = !rst && (fetch_q || data_cyc_q);
   assign o_address_latch_strobe = !rst && (sph < `ALE_END)
                                   && !(data_cyc_q && slot_b);
   assign o_program_read_strobe_n = !(!rst && fetch_q && sph >= `ADDR_END);

   assign o_shared_function_port_out = {!(!rst && rd_stb), !(!rst && wr_stb),
                                        4'hF, i_serial_out, 1'b1};
   assign o_shared_function_port_oe  = `SFP_OE_MASK;

endmodule // ext_bus_port

`default_nettype wire

// [sim/ext_bus_checker.sv]
// Assertion checker for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
module ext_bus_checker (
   input wire logic       i_clock,
   input wire logic       i_resetn,
   input wire logic       i_serial_out,
   input wire logic       o_reset_active,
   input wire logic       o_address_latch_strobe,
   input wire logic       o_program_read_strobe_n,
   input wire logic       o_low_addr_data_port_pullup,
   input wire logic [7:0] o_low_addr_data_port_out,
   input wire logic [7:0] o_low_addr_data_port_oe,
   input wire logic [7:0] o_shared_function_port_out,
   input wire logic [7:0] o_shared_function_port_oe
);
   wire ale = o_address_latch_strobe;
   wire psn = o_program_read_strobe_n;
   wire wrn = o_shared_function_port_out[6];
   wire rdn = o_shared_function_port_out[7];
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_resetn || o_reset_active);
   sequence ale_pulse;
      ale ##1 !ale [*4];
   endsequence
   sequence psn_pulse;
      !psn [*3] ##1 psn;
   endsequence
   a_ale_shape: assert property ($rose(ale) |=> ale_pulse)
      else $error("latch strobe shape wrong");
   a_ale_skip_one: assert property ($fell(ale) |-> ##[4:10] $rose(ale))
      else $error("latch strobe gap wrong");
   a_program_pulse_input_rd_width: assert property ($fell(psn) |-> psn_pulse)
      else $error("program strobe width wrong");
   a_strobe_excl: assert property (!psn |-> rdn && wrn)
      else $error("program and data strobes overlap");
   a_rd_float: assert property (!rdn |-> o_low_addr_data_port_oe == 8'h00 && !ale)
      else $error("low port driven during read");
   a_wr_hold: assert property (!wrn |=> o_low_addr_data_port_oe == 8'hFF && $stable(o_low_addr_data_port_out))
      else $error("write data not held");
   a_pullup_on: assert property ((!psn || !rdn || !wrn) |-> o_low_addr_data_port_pullup)
      else $error("pull-up off during access");
   a_sfp_map: assert property (o_shared_function_port_oe == 8'hC2 && o_shared_function_port_out[1] == i_serial_out)
      else $error("shared port map wrong");
endmodule // ext_bus_checker
bind ext_bus_port ext_bus_checker i_ext_bus_checker (.i_clock, .i_resetn, .i_serial_out,
   .o_reset_active, .o_address_latch_strobe, .o_program_read_strobe_n,
   .o_low_addr_data_port_pullup, .o_low_addr_data_port_out, .o_low_addr_data_port_oe,
   .o_shared_function_port_out, .o_shared_function_port_oe);
`default_nettype wire

// [sim/ext_mem_model.sv]
// External code and data memory with address latch
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   input  wire logic       i_ale,
   input  wire logic       i_program_pulse_input_rd_n,
   input  wire logic [7:0] i_sfp,
   input  wire logic [7:0] i_high,
   input  wire logic [7:0] i_out,
   input  wire logic [7:0] i_oe,
   output logic      [7:0] o_pin
);
   logic [7:0] lo_q;
   logic [7:0] drv;
   logic [7:0] mem [0:65535];
   wire  [15:0] addr = {i_high, lo_q};
   always_latch begin
      if (i_ale && i_oe == 8'hFF) lo_q = i_out;
   end
   always_comb begin
      drv = 8'hFF;
      if (!i_program_pulse_input_rd_n) drv = addr[7:0] ^ addr[15:8] ^ 8'h5A;
      if (!i_sfp[7]) drv = mem[addr];
   end
   assign o_pin = (i_oe & i_out) | (~i_oe & drv);
   always @(posedge i_sfp[6]) mem[addr] <= o_pin;
endmodule // ext_mem_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the external memory bus port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        i_clock, i_resetn, i_reset_pin, i_external_access_select, i_code_protect_bit_one;
   logic        i_fetch_valid, i_move_valid, i_move_write, i_move_use_pointer, i_rd_ready;
   logic        i_serial_out, stall;
   logic [15:0] i_fetch_addr, i_move_addr, a;
   logic [7:0]  i_move_wdata, i_high_port_latch, i_shared_function_port_in, v;
   wire         f_rdy, m_rdy, r_vld, r_code, ale, psn, ext, rst_act, ser_in;
   wire  [7:0]  r_data, p_out, p_oe, hi, s_out, pin;
   wire  [1:0]  irq, cnt;
   logic [8:0]  exp_q [$];
   logic [7:0]  mem_x [0:65535];
   integer      miscompares = 0, checked = 0, cycles = 0, seed = 32'h4DC4, i;
   ext_bus_port i_ext_bus_port (.i_clock, .i_resetn, .i_clock_enable(1'b1), .i_reset_pin,
      .i_external_access_select, .i_code_protect_bit_one, .i_fetch_valid, .i_fetch_addr,
      .o_fetch_ready(f_rdy), .i_move_valid, .i_move_write, .i_move_use_pointer, .i_move_addr,
      .i_move_wdata, .i_high_port_latch, .o_move_ready(m_rdy), .o_rd_valid(r_vld),
      .o_rd_data(r_data), .o_rd_is_code(r_code), .i_rd_ready, .i_low_addr_data_port_in(pin),
      .o_low_addr_data_port_out(p_out), .o_low_addr_data_port_oe(p_oe),
      .o_low_addr_data_port_pullup(), .o_high_addr_port(hi), .o_address_latch_strobe(ale),
      .o_program_read_strobe_n(psn), .i_shared_function_port_in,
      .o_shared_function_port_out(s_out), .o_shared_function_port_oe(), .i_serial_out,
      .o_serial_in(ser_in), .o_ext_irq(irq), .o_counter_input(cnt),
      .o_code_from_external(ext), .o_reset_active(rst_act));
   ext_mem_model i_ext_mem_model (.i_ale(ale), .i_program_pulse_input_rd_n(psn), .i_sfp(s_out), .i_high(hi),
      .i_out(p_out), .i_oe(p_oe), .o_pin(pin));
   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end
   task check(input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task fetch(input logic [15:0] fa);
      i_move_valid = 1'b0;
      i_fetch_valid = 1'b1;
      i_fetch_addr = fa;
      #1 while (f_rdy !== 1'b1) @(negedge i_clock) #1;
      exp_q.push_back({1'b1, fa[7:0] ^ fa[15:8] ^ 8'h5A});
      @(negedge i_clock);
   endtask
   task move(input logic wr, input logic ptr, input logic [15:0] ma, input logic [7:0] md);
      logic [15:0] eff_addr;
      eff_addr = {ptr ? ma[15:8] : i_high_port_latch, ma[7:0]};
      i_fetch_valid = 1'b0;
      {i_move_valid, i_move_write, i_move_use_pointer, i_move_addr, i_move_wdata} = {1'b1, wr, ptr, ma, md};
      #1 while (m_rdy !== 1'b1) @(negedge i_clock) #1;
      if (wr) mem_x[eff_addr] = md;
      else exp_q.push_back({1'b0, mem_x[eff_addr]});
      @(negedge i_clock);
   endtask
   always @(negedge i_clock) i_rd_ready <= stall ? 1'b0 : 1'($random(seed));
   always @(posedge i_clock) begin
      cycles++;
      if (i_resetn && !rst_act && r_vld === 1'b1 && i_rd_ready) begin
         if (exp_q.size() == 0) check(9'h000, 9'h1FF);
         else check({r_code, r_data}, exp_q.pop_front());
      end
      if (cycles == 20000) begin
         miscompares++;
         close_out;
      end
   end
   initial begin
      {i_resetn, i_reset_pin, i_external_access_select, i_code_protect_bit_one} = 4'h0;
      {i_fetch_valid, i_move_valid, i_move_write, i_move_use_pointer, stall} = 5'h01;
      {i_fetch_addr, i_move_addr, i_move_wdata, i_high_port_latch} = 48'h0;
      {i_serial_out, i_shared_function_port_in} = 9'h1FF;
      repeat (8) @(negedge i_clock);
      i_resetn = 1'b1;
      fetch(16'h1234);
      fetch(16'h4321);
      for (i = 0; i < 24; i++) begin
         @(negedge i_clock) #1 check({8'h00, f_rdy}, 9'h000);
      end
      stall = 1'b0;
      $display("test buffer full done");
      for (i = 0; i < 12; i++) fetch(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($random(seed)));
      for (i = 0; i < 6; i++) begin
         a = 16'($random(seed));
         i_high_port_latch = 8'($random(seed));
         move(1'b1, i[0], a, 8'($random(seed)));
         move(1'b0, 1'b1, i[0] ? a : {i_high_port_latch, a[7:0]}, 8'h00);
         fetch(a);
      end
      i_fetch_valid = 1'b0;
      for (i = 0; i < 300 && exp_q.size() > 0; i++) @(negedge i_clock);
      check({8'h00, exp_q.size() == 0}, 9'h001);
      $display("test moves done");
      v = 8'($random(seed));
      i_shared_function_port_in = v;
      i_serial_out = v[7];
      repeat (4) @(negedge i_clock);
      check({3'h0, ser_in, irq, cnt}, {3'h0, v[0], v[3:2], v[5:4]});
      i_external_access_select = 1'b1;
      repeat (4) @(negedge i_clock);
      check({8'h00, ext}, 9'h000);
      {i_code_protect_bit_one, i_external_access_select, i_resetn} = 3'h4;
      repeat (4) @(negedge i_clock);
      i_resetn = 1'b1;
      i_external_access_select = 1'b1;
      repeat (6) @(negedge i_clock);
      check({8'h00, ext}, 9'h001);
      i_reset_pin = 1'b1;
      repeat (20) @(negedge i_clock);
      check({8'h00, rst_act}, 9'h000);
      repeat (10) @(negedge i_clock);
      check({8'h00, rst_act}, 9'h001);
      i_reset_pin = 1'b0;
      repeat (6) @(negedge i_clock);
      check({8'h00, rst_act}, 9'h000);
      check({8'h00, ext}, 9'h000);
      $display("test straps and reset done");
      close_out;
   end
endmodule // tb_top
`default_nettype wire
